// *** logic/gpbcs_top.sv ***
// How it works
// - Byte access of byte port uses low lanes.
// - Memory targets use memory strobes instead.
// - Halfword access of halfword port uses sixteen lanes.
// - Halfword from byte port reports byte width.
// - Word from byte port reports byte width.
// - Word from halfword port reports halfword width.
// - Byte-high enable and address bit pick lanes.
// - Each chip select has programmed port width.
// - Wide request pin makes width halfword.
// - Halfword if programmed or requested, else byte.
// - Wide request never changes cycle timing.
// - Wide request shares ready sampling deadline.
// - Programmed offset delays command strobes.
// - Ready never shortens the programmed strobe.
// - Each ready-low cycle after the programmed width adds one wait.
// - Strobe ends after width and synchronized ready.
// - Interrupt lines bypass the controller.
`timescale 1ns/100ps
`default_nettype none
`include "gpbcs_defs.svh"
module gpbcs_top (
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire logic [15:0] AV_ADDRESS,
   input wire logic AV_READ,
   input wire logic AV_WRITE,
   input wire logic [31:0] AV_WRITEDATA,
   input wire logic [3:0] AV_BYTEENABLE,
   output logic [31:0] AV_READDATA,
   output logic AV_WAITREQUEST,
   input wire logic CPU_REQ_VALID,
   input wire gpbcs_pkg::gpbcs_req_s CPU_REQ_INFO,
   output logic CPU_REQ_READY,
   output logic CPU_DONE,
   output logic [15:0] CPU_RDATA,
   output logic CPU_BYTE_SIZE_N,
   output logic CPU_HALF_SIZE_N,
   output logic [7:0] EXT_CS_N,
   output logic EXT_ADDR_LSB,
   output logic BYTE_HIGH_ENABLE_N,
   output logic IO_READ_STROBE_N,
   output logic IO_WRITE_STROBE_N,
   output logic MEM_READ_STROBE_N,
   output logic MEM_WRITE_STROBE_N,
   input wire logic [15:0] EXT_DATA_BUS_I,
   output logic [15:0] EXT_DATA_BUS_O,
   output logic [15:0] EXT_DATA_BUS_OE,
   input wire logic IO_WIDE_REQUEST_N,
   input wire logic MEM_WIDE_REQUEST_N,
   input wire logic EXT_READY,
   input wire logic [10:0] EXT_IRQ_LINES,
   output logic [10:0] PIC_IRQ_LINES
);
   import gpbcs_pkg::*;

   // ----------------------------------------
   // Reset release and input synchronizer
   // ----------------------------------------
   logic [1:0] rst_pipe_q;
   logic rst_n_s;
   logic [2:0] pin_s;
   logic ready_s;
   logic wide_s;

   // Reset asserts at once and releases after two edges.
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_pipe_q <= 2'h0;
      end else begin
         rst_pipe_q <= {rst_pipe_q[0], 1'b1};
      end
   end
   assign rst_n_s = rst_pipe_q[1];

   // Ready and both wide pins share one path, so one deadline applies.
   gpbcs_sync i_gpbcs_sync (
      .clk(REF_CLK),
      .rst_n(rst_n_s),
      .d({EXT_READY, IO_WIDE_REQUEST_N, MEM_WIDE_REQUEST_N}),
      .q(pin_s)
   );
   assign ready_s = pin_s[2];
   assign wide_s = !pin_s[1] || !pin_s[0];

   // Interrupt lines go straight to the interrupt controller.
   assign PIC_IRQ_LINES = EXT_IRQ_LINES;

   // ----------------------------------------
   // Register file on the Avalon slave
   // ----------------------------------------
   logic [7:0] width_q;
   logic [7:0] width_d;
   logic [11:0] timing_q;
   logic [11:0] timing_d;
   logic ack_q;
   logic ack_d;
   logic [31:0] rd_q;
   logic [31:0] rd_d;
   logic [31:0] status;
   logic av_req;
   logic waited_q;
   logic half_n_q;
   gpbcs_state_e state_q;

   assign av_req = AV_READ || AV_WRITE;
   // Every access waits exactly one cycle.
   assign AV_WAITREQUEST = av_req && !ack_q;
   assign AV_READDATA = rd_q;

   // Status shows the cycle engine's state and the synchronized ready pin.
   always_comb begin
      status = 32'h0000_0000;
      status[`GPBCS_ST_BUSY] = (state_q != GPBCS_IDLE);
      status[`GPBCS_ST_HALF] = !half_n_q;
      status[`GPBCS_ST_READY] = ready_s;
      status[`GPBCS_ST_WAIT] = waited_q;
   end

   // Decode, byte-lane writes and read data capture.
   always_comb begin
      width_d = width_q;
      timing_d = timing_q;
      rd_d = rd_q;
      ack_d = av_req && !ack_q;
      if (av_req && !ack_q && AV_READ) begin
         case (AV_ADDRESS)
            {`GPBCS_WIDTH_IDX, 2'b00}: rd_d = {24'h00_0000, width_q};
            {`GPBCS_TIMING_IDX, 2'b00}: rd_d = {20'h0_0000, timing_q};
            {`GPBCS_STATUS_IDX, 2'b00}: rd_d = status;
            default: rd_d = 32'h0000_0000;
         endcase
      end
      if (ack_q && AV_WRITE) begin
         if (AV_ADDRESS == {`GPBCS_WIDTH_IDX, 2'b00} && AV_BYTEENABLE[0]) begin
            width_d = AV_WRITEDATA[7:0];
         end
         if (AV_ADDRESS == {`GPBCS_TIMING_IDX, 2'b00}) begin
            if (AV_BYTEENABLE[0]) begin
               timing_d[7:0] = AV_WRITEDATA[7:0];
            end
            if (AV_BYTEENABLE[1]) begin
               timing_d[11:8] = AV_WRITEDATA[11:8];
            end
         end
      end
   end

   // Register group for the slave.
   always_ff @(posedge REF_CLK or negedge rst_n_s) begin
      if (!rst_n_s) begin
         width_q <= `GPBCS_WIDTH_RST;
         timing_q <= `GPBCS_TIMING_RST;
         ack_q <= 1'b0;
         rd_q <= 32'h0000_0000;
      end else begin
         width_q <= width_d;
         timing_q <= timing_d;
         ack_q <= ack_d;
         rd_q <= rd_d;
      end
   end

   // ----------------------------------------
   // External bus cycle engine
   // ----------------------------------------
   gpbcs_state_e state_d;
   gpbcs_req_s req_q;
   gpbcs_req_s req_d;
   logic [11:0] lat_q;
   logic [11:0] lat_d;
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic prog16_q;
   logic prog16_d;
   logic wide_q;
   logic wide_d;
   logic waited_d;
   logic done_q;
   logic done_d;
   logic [15:0] rdata_q;
   logic [15:0] rdata_d;
   logic byte_n_q;
   logic byte_n_d;
   logic half_n_d;
   logic [15:0] dout_q;
   logic [15:0] dout_d;
   logic [15:0] oe_q;
   logic [15:0] oe_d;
   logic wide16_now;
   logic wide16_nx;
   logic odd8;
   logic strobe_on;
   logic cyc_on;

   // Port width is halfword when programmed or requested.
   assign wide16_now = prog16_q || wide_q || wide_s;

   // Phase sequencing, width sampling and lane steering.
   always_comb begin
      state_d = state_q;
      req_d = req_q;
      lat_d = lat_q;
      cnt_d = cnt_q;
      prog16_d = prog16_q;
      wide_d = wide_q;
      waited_d = waited_q;
      done_d = 1'b0;
      rdata_d = rdata_q;
      byte_n_d = byte_n_q;
      half_n_d = half_n_q;
      odd8 = req_q.byte_high_enable_n && req_q.addr_lsb;
      case (state_q)
         GPBCS_IDLE: begin
            if (CPU_REQ_VALID) begin
               req_d = CPU_REQ_INFO;
               lat_d = timing_q;
               prog16_d = width_q[CPU_REQ_INFO.cs];
               cnt_d = timing_q[`GPBCS_TIM_OFF];
               wide_d = 1'b0;
               waited_d = 1'b0;
               state_d = GPBCS_OFFSET;
            end
         end
         GPBCS_OFFSET: begin
            wide_d = wide_q || wide_s;
            if (cnt_q == 4'h0) begin
               state_d = GPBCS_PULSE;
               cnt_d = lat_q[`GPBCS_TIM_PW];
            end else begin
               cnt_d = cnt_q - 4'h1;
            end
         end
         GPBCS_PULSE: begin
            wide_d = wide_q || wide_s;
            if (cnt_q != 4'h0) begin
               cnt_d = cnt_q - 4'h1;
            end else if (!ready_s) begin
               waited_d = 1'b1;
            end else begin
               state_d = GPBCS_RECOVER;
               cnt_d = lat_q[`GPBCS_TIM_REC];
               done_d = 1'b1;
               half_n_d = !wide16_now;
               byte_n_d = wide16_now;
               if (wide16_now) begin
                  rdata_d = EXT_DATA_BUS_I;
               end else if (odd8) begin
                  rdata_d = {EXT_DATA_BUS_I[7:0], 8'h00};
               end else begin
                  rdata_d = {8'h00, EXT_DATA_BUS_I[7:0]};
               end
            end
         end
         GPBCS_RECOVER: begin
            if (cnt_q == 4'h0) begin
               state_d = GPBCS_IDLE;
            end else begin
               cnt_d = cnt_q - 4'h1;
            end
         end
         default: begin
            state_d = GPBCS_IDLE;
         end
      endcase
      // Write lanes follow byte-high enable, address bit and width.
      wide16_nx = prog16_d || wide_d;
      oe_d = 16'h0000;
      dout_d = dout_q;
      if ((state_d == GPBCS_OFFSET || state_d == GPBCS_PULSE) && req_d.write) begin
         if (!req_d.byte_high_enable_n && (wide16_nx || req_d.addr_lsb)) begin
            oe_d[15:8] = 8'hFF;
         end
         if (req_d.byte_high_enable_n || !req_d.addr_lsb) begin
            oe_d[7:0] = 8'hFF;
         end
         dout_d[15:8] = req_d.wdata[15:8];
         if (req_d.byte_high_enable_n && req_d.addr_lsb) begin
            dout_d[7:0] = req_d.wdata[15:8];
         end else begin
            dout_d[7:0] = req_d.wdata[7:0];
         end
      end
   end

   // Register group for the cycle engine.
   always_ff @(posedge REF_CLK or negedge rst_n_s) begin
      if (!rst_n_s) begin
         state_q <= GPBCS_IDLE;
         req_q <= '0;
         lat_q <= `GPBCS_TIMING_RST;
         cnt_q <= 4'h0;
         prog16_q <= 1'b0;
         wide_q <= 1'b0;
         waited_q <= 1'b0;
         done_q <= 1'b0;
         rdata_q <= 16'h0000;
         byte_n_q <= 1'b1;
         half_n_q <= 1'b1;
         dout_q <= 16'h0000;
         oe_q <= 16'h0000;
      end else begin
         state_q <= state_d;
         req_q <= req_d;
         lat_q <= lat_d;
         cnt_q <= cnt_d;
         prog16_q <= prog16_d;
         wide_q <= wide_d;
         waited_q <= waited_d;
         done_q <= done_d;
         rdata_q <= rdata_d;
         byte_n_q <= byte_n_d;
         half_n_q <= half_n_d;
         dout_q <= dout_d;
         oe_q <= oe_d;
      end
   end

   // CPU side answers and external pins.
   assign CPU_REQ_READY = (state_q == GPBCS_IDLE);
   assign CPU_DONE = done_q;
   assign CPU_RDATA = rdata_q;
   assign CPU_BYTE_SIZE_N = byte_n_q;
   assign CPU_HALF_SIZE_N = half_n_q;
   assign EXT_ADDR_LSB = req_q.addr_lsb;
   assign BYTE_HIGH_ENABLE_N = req_q.byte_high_enable_n;
   assign EXT_DATA_BUS_O = dout_q;
   assign EXT_DATA_BUS_OE = oe_q;
   assign strobe_on = (state_q == GPBCS_PULSE);
   assign cyc_on = (state_q == GPBCS_OFFSET) || strobe_on;
   // Memory targets swap the strobe pair, timing unchanged.
   assign IO_READ_STROBE_N = !(strobe_on && !req_q.write && !req_q.mem);
   assign IO_WRITE_STROBE_N = !(strobe_on && req_q.write && !req_q.mem);
   assign MEM_READ_STROBE_N = !(strobe_on && !req_q.write && req_q.mem);
   assign MEM_WRITE_STROBE_N = !(strobe_on && req_q.write && req_q.mem);

   // One chip select per channel, active through offset and pulse.
   for (genvar i = 0; i < 8; i++) begin : g_cs
      assign EXT_CS_N[i] = !(cyc_on && (req_q.cs == 3'(i)));
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   logic [4:0] off_len_q;
   logic [4:0] str_len_q;
   logic any_io;

   // Cycle-length counters used only by the checks.
   always_ff @(posedge REF_CLK or negedge rst_n_s) begin
      if (!rst_n_s) begin
         off_len_q <= 5'h00;
         str_len_q <= 5'h00;
      end else if (state_q == GPBCS_IDLE) begin
         off_len_q <= 5'h00;
         str_len_q <= 5'h00;
      end else begin
         off_len_q <= off_len_q + 5'(state_q == GPBCS_OFFSET);
         str_len_q <= str_len_q + 5'(strobe_on && str_len_q != 5'h1F);
      end
   end
   assign any_io = !IO_READ_STROBE_N || !IO_WRITE_STROBE_N;

   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!rst_n_s);

   offset_len_a: assert property ($rose(strobe_on) |->
      off_len_q == 5'(lat_q[`GPBCS_TIM_OFF]) + 5'h01) else $error("strobe offset wrong");
   strobe_min_a: assert property ($fell(strobe_on) |->
      str_len_q >= 5'(lat_q[`GPBCS_TIM_PW]) + 5'h01) else $error("strobe too short");
   ready_hold_a: assert property (strobe_on && cnt_q == 4'h0 && !ready_s
      |=> strobe_on) else $error("strobe released without ready");
   wait_end_a: assert property (strobe_on && cnt_q == 4'h0 && ready_s
      |=> !strobe_on ##0 CPU_DONE) else $error("strobe not released");
   mem_strobe_a: assert property (strobe_on && req_q.mem |-> !any_io)
      else $error("io strobe on memory cycle");
   low_lane_a: assert property (strobe_on && !wide16_now && req_q.byte_high_enable_n
      |-> EXT_DATA_BUS_OE[15:8] == 8'h00) else $error("high lanes driven");
   full_lane_a: assert property (strobe_on && req_q.write && prog16_q &&
      !req_q.byte_high_enable_n && !req_q.addr_lsb |-> EXT_DATA_BUS_OE == 16'hFFFF)
      else $error("not all lanes driven");
   width_rep_a: assert property (CPU_DONE |-> (CPU_HALF_SIZE_N != CPU_BYTE_SIZE_N) &&
      (CPU_HALF_SIZE_N == !(prog16_q || wide_q))) else $error("reported width wrong");
   ready_sync_a: assert property ($past(rst_n_s, 2) |->
      ready_s == $past(EXT_READY, 2)) else $error("ready latency wrong");

   wait_cycle_c: cover property (strobe_on && cnt_q == 4'h0 && !ready_s ##1 ready_s);
   wide_override_c: cover property (CPU_DONE && !prog16_q && !CPU_HALF_SIZE_N);
   mem_write_c: cover property (!MEM_WRITE_STROBE_N ##1 MEM_WRITE_STROBE_N);
   reg_write_c: cover property (AV_WRITE && !AV_WAITREQUEST);
endmodule // gpbcs_top
`default_nettype wire

// *** include/gpbcs_defs.svh ***
`ifndef GPBCS_DEFS_SVH
`define GPBCS_DEFS_SVH
// ----------------------------------------
// Register indices; byte address = index * 4.
// ----------------------------------------
`define GPBCS_WIDTH_IDX 14'h0C01
`define GPBCS_TIMING_IDX 14'h0C08
`define GPBCS_STATUS_IDX 14'h0C09
// ----------------------------------------
// Reset values.
// ----------------------------------------
`define GPBCS_WIDTH_RST 8'h00
`define GPBCS_TIMING_RST 12'h210
`define GPBCS_SYNC_RST 3'h7
// ----------------------------------------
// Field positions of the timing and status registers.
// ----------------------------------------
`define GPBCS_TIM_OFF 3:0
`define GPBCS_TIM_PW 7:4
`define GPBCS_TIM_REC 11:8
`define GPBCS_ST_BUSY 0
`define GPBCS_ST_HALF 1
`define GPBCS_ST_READY 2
`define GPBCS_ST_WAIT 3
`endif

// *** include/gpbcs_pkg.sv ***
// ----------------------------------------
// Types shared by the bus cycle controller.
// ----------------------------------------
package gpbcs_pkg;
   // Phases of one external bus cycle.
   typedef enum logic [1:0] {
      GPBCS_IDLE,
      GPBCS_OFFSET,
      GPBCS_PULSE,
      GPBCS_RECOVER
   } gpbcs_state_e;

   // One access request from the CPU side.
   typedef struct packed {
      logic write;
      logic mem;
      logic [2:0] cs;
      logic addr_lsb;
      logic byte_high_enable_n;
      logic [15:0] wdata;
   } gpbcs_req_s;
endpackage

// *** logic/gpbcs_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "gpbcs_defs.svh"
// ----------------------------------------
// Two-stage synchronizer for ready and the two wide request pins.
// ----------------------------------------
module gpbcs_sync (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [2:0] d,
   output logic [2:0] q
);
   logic [2:0] meta_q;
   logic [2:0] meta_d;
   logic [2:0] sync_q;
   logic [2:0] sync_d;

   // The first stage feeds only the second stage.
   always_comb begin
      meta_d = d;
      sync_d = meta_q;
   end

   // Both stages idle high, which reads as ready and not wide.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= `GPBCS_SYNC_RST;
         sync_q <= `GPBCS_SYNC_RST;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign q = sync_q;
endmodule // gpbcs_sync
`default_nettype wire

// *** bench/gpbcs_periph.sv ***
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Peripheral model on the far side of the bus.
// ----------------------------------------
module gpbcs_periph #(parameter logic [15:0] PAT = 16'h5AC3) (
   input wire logic clk,
   input wire logic [7:0] cs_n,
   input wire logic rd_n,
   input wire logic any_n,
   input wire logic [1:0] wide,
   input wire logic [7:0] hold,
   output logic [15:0] data,
   output logic io_wide_n,
   output logic mem_wide_n,
   output logic ready
);
   logic [15:0] last_q = 16'h0000;
   logic [7:0] cnt_q = 8'h00;
   logic sel_q = 1'b0;
   logic sel;
   // A released bus flips every cycle so stale data never looks valid.
   assign data = rd_n ? ~last_q : PAT;
   assign sel = !(&cs_n);
   // Ready drops with chip select and rises after hold strobe cycles.
   assign ready = !(sel && cnt_q < hold);
   // Wide request rises with chip select and falls a cycle after it.
   assign io_wide_n = !((sel || sel_q) && wide[0]);
   assign mem_wide_n = !((sel || sel_q) && wide[1]);
   // Cycle history for the bus and the strobe counter.
   always @(posedge clk) begin
      last_q <= data;
      sel_q <= sel;
      cnt_q <= any_n ? 8'h00 : cnt_q + 8'h01;
   end
endmodule // gpbcs_periph
`default_nettype wire

// *** bench/gpbcs_top_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module gpbcs_top_bench;
   import gpbcs_pkg::*;
   logic REF_CLK = 1'b0;
   logic RST_N = 1'b0;
   logic [15:0] AV_ADDRESS = 16'h0000;
   logic AV_READ = 1'b0;
   logic AV_WRITE = 1'b0;
   logic [31:0] AV_WRITEDATA = 32'h0;
   logic [3:0] AV_BYTEENABLE = 4'hF;
   logic CPU_REQ_VALID = 1'b0;
   gpbcs_req_s CPU_REQ_INFO = '0;
   logic [10:0] EXT_IRQ_LINES = 11'h000;
   logic [1:0] wide = 2'b00;
   logic [7:0] hold = 8'h00;
   logic [31:0] AV_READDATA;
   logic AV_WAITREQUEST, CPU_REQ_READY, CPU_DONE, CPU_BYTE_SIZE_N, CPU_HALF_SIZE_N;
   logic [15:0] CPU_RDATA, EXT_DATA_BUS_I, EXT_DATA_BUS_O, EXT_DATA_BUS_OE;
   logic [7:0] EXT_CS_N;
   logic EXT_ADDR_LSB, BYTE_HIGH_ENABLE_N, IO_READ_STROBE_N, IO_WRITE_STROBE_N;
   logic MEM_READ_STROBE_N, MEM_WRITE_STROBE_N, IO_WIDE_REQUEST_N, MEM_WIDE_REQUEST_N;
   logic EXT_READY;
   logic [10:0] PIC_IRQ_LINES;
   logic [15:0] rd, oe, dout;
   logic bs8n, bs16n, iol, meml;
   logic [31:0] q;
   int offc, strc, sa, bad_count = 0, tests_run = 0, cyc = 0;

   gpbcs_top i_gpbcs_top (.REF_CLK(REF_CLK), .RST_N(RST_N), .AV_ADDRESS(AV_ADDRESS),
      .AV_READ(AV_READ), .AV_WRITE(AV_WRITE), .AV_WRITEDATA(AV_WRITEDATA),
      .AV_BYTEENABLE(AV_BYTEENABLE), .AV_READDATA(AV_READDATA),
      .AV_WAITREQUEST(AV_WAITREQUEST), .CPU_REQ_VALID(CPU_REQ_VALID),
      .CPU_REQ_INFO(CPU_REQ_INFO), .CPU_REQ_READY(CPU_REQ_READY), .CPU_DONE(CPU_DONE),
      .CPU_RDATA(CPU_RDATA), .CPU_BYTE_SIZE_N(CPU_BYTE_SIZE_N),
      .CPU_HALF_SIZE_N(CPU_HALF_SIZE_N), .EXT_CS_N(EXT_CS_N), .EXT_ADDR_LSB(EXT_ADDR_LSB),
      .BYTE_HIGH_ENABLE_N(BYTE_HIGH_ENABLE_N), .IO_READ_STROBE_N(IO_READ_STROBE_N),
      .IO_WRITE_STROBE_N(IO_WRITE_STROBE_N), .MEM_READ_STROBE_N(MEM_READ_STROBE_N),
      .MEM_WRITE_STROBE_N(MEM_WRITE_STROBE_N), .EXT_DATA_BUS_I(EXT_DATA_BUS_I),
      .EXT_DATA_BUS_O(EXT_DATA_BUS_O), .EXT_DATA_BUS_OE(EXT_DATA_BUS_OE),
      .IO_WIDE_REQUEST_N(IO_WIDE_REQUEST_N), .MEM_WIDE_REQUEST_N(MEM_WIDE_REQUEST_N),
      .EXT_READY(EXT_READY), .EXT_IRQ_LINES(EXT_IRQ_LINES), .PIC_IRQ_LINES(PIC_IRQ_LINES));

   gpbcs_periph i_gpbcs_periph (.clk(REF_CLK), .cs_n(EXT_CS_N),
      .rd_n(IO_READ_STROBE_N & MEM_READ_STROBE_N),
      .any_n(&{IO_READ_STROBE_N, IO_WRITE_STROBE_N, MEM_READ_STROBE_N, MEM_WRITE_STROBE_N}),
      .wide(wide), .hold(hold), .data(EXT_DATA_BUS_I), .io_wide_n(IO_WIDE_REQUEST_N),
      .mem_wide_n(MEM_WIDE_REQUEST_N), .ready(EXT_READY));

   // ----------------------------------------
   // Clock, timeout and shared tasks.
   // ----------------------------------------
   // The clock toggles every half period of 10 ns.
   initial begin
      forever #10 REF_CLK = ~REF_CLK;
   end

   // A hung wait ends the run after a generous cycle ceiling.
   always @(posedge REF_CLK) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         summarize();
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One register access; the request stands until waitrequest is seen low.
   task automatic av(input logic w, input logic [15:0] a, input logic [31:0] d);
      AV_ADDRESS <= a;
      AV_WRITE <= w;
      AV_READ <= !w;
      AV_WRITEDATA <= d;
      do @(posedge REF_CLK); while (AV_WAITREQUEST !== 1'b0);
      q = AV_READDATA;
      AV_READ <= 1'b0;
      AV_WRITE <= 1'b0;
      @(posedge REF_CLK);
   endtask

   // One CPU access; offset and strobe cycles are counted while it runs.
   task automatic cpu(input logic w, m, input logic [2:0] cs, input logic a0, bhe,
                      input logic [15:0] wd);
      int n;
      logic [7:0] csn;
      logic [7:0] cs_exp;
      logic [1:0] ab;
      n = 0;
      cs_exp = ~(8'h01 << cs);
      csn = 8'hFF;
      ab = 2'b00;
      offc = 0;
      strc = 0;
      iol = 1'b0;
      meml = 1'b0;
      CPU_REQ_VALID <= 1'b1;
      CPU_REQ_INFO <= '{w, m, cs, a0, bhe, wd};
      do @(posedge REF_CLK); while (CPU_REQ_READY !== 1'b1);
      CPU_REQ_VALID <= 1'b0;
      do begin
         @(negedge REF_CLK);
         n++;
         iol = iol | !(IO_READ_STROBE_N & IO_WRITE_STROBE_N);
         meml = meml | !(MEM_READ_STROBE_N & MEM_WRITE_STROBE_N);
         if (!(IO_READ_STROBE_N & IO_WRITE_STROBE_N & MEM_READ_STROBE_N & MEM_WRITE_STROBE_N)) begin
            strc++;
            oe = EXT_DATA_BUS_OE;
            dout = EXT_DATA_BUS_O;
            csn = EXT_CS_N;
            ab = {EXT_ADDR_LSB, BYTE_HIGH_ENABLE_N};
         end else if (strc == 0) begin
            offc++;
         end
      end while (CPU_DONE !== 1'b1 && n < 500);
      chk("done", 1, CPU_DONE);
      chk("chip select", cs_exp, csn);
      chk("addr and enable", {a0, bhe}, ab);
      rd = CPU_RDATA;
      bs8n = CPU_BYTE_SIZE_N;
      bs16n = CPU_HALF_SIZE_N;
      @(posedge REF_CLK);
   endtask

   // ----------------------------------------
   // Scenarios.
   // ----------------------------------------
   task automatic t_regs();
      av(0, 16'h3004, 32'h0);
      chk("width reset", 32'h0, q);
      av(0, 16'h3020, 32'h0);
      chk("timing reset", 32'h210, q);
      av(1, 16'h3100, 32'hFF);
      av(0, 16'h3100, 32'h0);
      chk("unmapped", 32'h0, q);
      av(1, 16'h3004, 32'h02);
      av(0, 16'h3004, 32'h0);
      chk("width rw", 32'h02, q);
      $display("done regs");
   endtask

   task automatic t_byte();
      logic [15:0] wd;
      cpu(0, 0, 3'h0, 0, 1, 16'h0);
      chk("low lane", 8'hC3, rd[7:0]);
      chk("io strobe", 2'b10, {iol, meml});
      chk("byte size", 2'b01, {bs8n, bs16n});
      chk("offset", 1, offc);
      chk("pulse", 2, strc);
      cpu(0, 0, 3'h0, 1, 1, 16'h0);
      chk("odd byte", 8'hC3, rd[15:8]);
      for (int i = 0; i < 4; i++) begin
         wd = {8'hA0 + 8'(i), 8'h50 + 8'(i)};
         cpu(1, 1, 3'h0, i[0], 1, wd);
         chk("split lanes", 16'h00FF, oe);
         chk("split data", i[0] ? wd[15:8] : wd[7:0], dout[7:0]);
         chk("split size", 2'b01, {bs8n, bs16n});
         chk("mem strobe", 2'b01, {iol, meml});
      end
      $display("done byte");
   endtask

   task automatic t_half();
      cpu(1, 1, 3'h1, 0, 0, 16'h1234);
      chk("full lanes", 16'hFFFF, oe);
      chk("full data", 16'h1234, dout);
      chk("mem write", 2'b01, {iol, meml});
      chk("half size", 2'b10, {bs8n, bs16n});
      cpu(0, 1, 3'h1, 0, 0, 16'h0);
      chk("full read", 16'h5AC3, rd);
      cpu(1, 0, 3'h1, 1, 0, 16'hAB00);
      chk("upper lane", 16'hFF00, oe);
      chk("upper data", 8'hAB, dout[15:8]);
      cpu(1, 0, 3'h1, 0, 1, 16'h00CD);
      chk("lower lane", 16'h00FF, oe);
      $display("done half");
   endtask

   task automatic t_wide();
      wide <= 2'b01;
      cpu(0, 0, 3'h0, 0, 1, 16'h0);
      chk("io wide size", 2'b10, {bs8n, bs16n});
      chk("wide offset", 1, offc);
      chk("wide pulse", 2, strc);
      wide <= 2'b10;
      cpu(0, 1, 3'h0, 0, 1, 16'h0);
      chk("mem wide size", 2'b10, {bs8n, bs16n});
      wide <= 2'b00;
      $display("done wide");
   endtask

   task automatic t_wait();
      av(1, 16'h3020, 32'h32);
      cpu(0, 0, 3'h0, 0, 1, 16'h0);
      chk("long offset", 3, offc);
      chk("long pulse", 4, strc);
      hold <= 8'h06;
      cpu(0, 0, 3'h0, 0, 1, 16'h0);
      sa = strc;
      chk("ready stretch", 9, strc);
      hold <= 8'h09;
      cpu(0, 0, 3'h0, 0, 1, 16'h0);
      chk("wait per cycle", 3, strc - sa);
      av(0, 16'h3024, 32'h0);
      chk("status", 32'h0000_000C, q);
      hold <= 8'h00;
      $display("done wait");
   endtask

   task automatic t_irq();
      EXT_IRQ_LINES <= 11'h5A5;
      @(negedge REF_CLK);
      chk("irq pass", 11'h5A5, PIC_IRQ_LINES);
      @(posedge REF_CLK);
      EXT_IRQ_LINES <= 11'h25A;
      @(negedge REF_CLK);
      chk("irq pass", 11'h25A, PIC_IRQ_LINES);
      @(posedge REF_CLK);
      $display("done irq");
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Reset for 16 cycles, then run every scenario.
   initial begin
      repeat (16) @(posedge REF_CLK);
      RST_N <= 1'b1;
      repeat (3) @(posedge REF_CLK);
      t_regs();
      t_byte();
      t_half();
      t_wide();
      t_wait();
      t_irq();
      summarize();
   end
endmodule // gpbcs_top_bench
`default_nettype wire
